// ==== src/cfm_pkg.sv ====
// Shared constants, configuration and status carriers of the fault manager.
// Assumes a 200 MHz core clock; the core-cycle counts below derive from that rate.
package cfm_pkg;

  // Clock rate and derived cycle counts
  localparam int CLK_KHZ = 200000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SAMPLE_NS = 75;
  localparam int SAMPLE_CYCLES = (SAMPLE_NS * 1000 + CLK_PERIOD_PS - 1) /
                                 CLK_PERIOD_PS;
  localparam int MS_CYCLES = CLK_KHZ;
  localparam int HICCUP_MS = 20;

  // Switching frequency range in kHz
  localparam logic [10:0] FREQ_MIN_KHZ = 11'h1f4;
  localparam logic [10:0] FREQ_MAX_KHZ = 11'h5dc;
  localparam int SET_SHIFT = 3;

  // Over-current sequencing
  localparam int OC_TOTAL_MAX = 8;
  localparam logic [1:0] OC_STEP_RUN = 2'h3;
  localparam logic [2:0] OC_RECOVER_RUN = 3'h4;
  localparam logic [1:0] STEP_MAX = 2'h3;
  localparam logic [7:0] DUTY_HALF = 8'h80;
  localparam logic [7:0] DUTY_QUARTER = 8'h40;
  localparam logic [7:0] DUTY_EIGHTH = 8'h20;

  // Temperature handling, degrees C
  localparam logic [8:0] TEMP_OFFSET = 9'h028;
  localparam logic [8:0] OT_HYST = 9'h019;
  localparam logic [7:0] OT_TRIP_DEFAULT = 8'h7d;

  // Over-temperature responses
  localparam logic [1:0] OT_IGNORE = 2'h0;
  localparam logic [1:0] OT_INHIBIT = 2'h1;
  localparam logic [1:0] OT_LATCH = 2'h2;

  // Settings held by the management side
  typedef struct packed {
    logic [10:0] freqKhz;
    logic busMode;
    logic opCtrl;
    logic opOn;
    logic softOff;
    logic [6:0] offDelayMs;
    logic [6:0] stopMs;
    logic [5:0] ocLimitA;
    logic ocLatch;
    logic [11:0] warnLimit;
    logic [7:0] otLimit;
    logic [1:0] otResp;
    logic [7:0] dutyNom;
  } cfm_cfg_type;

  // Readback flags
  typedef struct packed {
    logic ocWarn;
    logic ocFault;
    logic otFault;
    logic latched;
    logic softStop;
    logic [1:0] dutyStep;
  } cfm_status_type;

  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_RUN = 6'h02,
    ST_DELAY = 6'h04,
    ST_SOFT = 6'h08,
    ST_HICCUP = 6'h10,
    ST_LATCHED = 6'h20
  } cfm_state_type;

endpackage

// ==== src/cfm_period_div.sv ====
// Free-running divider: switching period in core cycles from a kHz setting.
// Assumes the setting is already clamped to the supported range.
`timescale 1ns/10ps
module cfm_period_div #(
  parameter int DIVIDEND = 200000
) (
  // Clock and control
  input wire logic clk,
  input wire logic rstSync_n,
  input wire logic ce,
  // Divisor and result
  input wire logic [10:0] divisor,
  output logic [15:0] period
);
  localparam logic [17:0] DIVIDEND_W = 18'(DIVIDEND);
  logic [11:0] rem;
  logic [17:0] quo;
  logic [4:0] bitIdx;
  logic [11:0] trial;

  // Restoring division; a fresh result lands every 19 cycles
  assign trial = {rem[10:0], quo[17]};

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      // Start a fresh division; period holds 400 until the first real quotient lands
      rem <= 12'h000;
      quo <= DIVIDEND_W;
      bitIdx <= 5'h12;
      period <= 16'h0190;
    end else if (ce) begin
      if (bitIdx == 5'h00) begin
        period <= quo[15:0];
        quo <= DIVIDEND_W;
        rem <= 12'h000;
        bitIdx <= 5'h12;
      end else if (trial >= {1'b0, divisor}) begin
        rem <= trial - {1'b0, divisor};
        quo <= {quo[16:0], 1'b1};
        bitIdx <= bitIdx - 5'h01;
      end else begin
        rem <= trial;
        quo <= {quo[16:0], 1'b0};
        bitIdx <= bitIdx - 5'h01;
      end
    end
  end
endmodule

// ==== src/cfm_ms_countdown.sv ====
// Millisecond countdown: loads a count, pulses done when it runs out.
// Assumes a one-cycle tick per millisecond from the caller.
`timescale 1ns/10ps
module cfm_ms_countdown #(
  parameter int W = 7
) (
  // Clock and control
  input wire logic clk,
  input wire logic rstSync_n,
  input wire logic ce,
  input wire logic tick,
  // Load and result
  input wire logic load,
  input wire logic [W-1:0] loadMs,
  output logic busy,
  output logic done
);
  logic [W-1:0] remaining;

  // First tick may come early, so a delay is short by under one ms
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      remaining <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (load) begin
        remaining <= loadMs;
        busy <= (loadMs != '0);
        done <= (loadMs == '0);
      end else if (busy && tick) begin
        remaining <= remaining - W'(1);
        if (remaining == W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== src/cfm_fault_manager.sv ====
// Converter fault manager: switching timing, shutdown sequencing,
// over-current and over-temperature protection, telemetry readback.
// Assumes comparator, enable and ADC inputs are synchronous to core_clk.
`timescale 1ns/10ps
//
// Contract
// - Switching frequency accepted anywhere between 500 kHz and 1.5 MHz.
// - Default: enable low turns both drivers off at once, no delay.
// - When configured, the operation command also shuts conversion down.
// - Bus mode with soft-off waits 0-127 ms turn-off delay first.
// - Bus mode soft-stop ramp lasts 1-127 ms in 1 ms steps.
// - Average current reported in sixteenths of an ampere.
// - Eight-bit current readback byte in quarter amperes.
// - Warning compares average current against the warning limit.
// - Current sampled about 75 ns from set pulse rise; pulse is period/8.
// - High-side on-pulse starts at the set pulse falling edge.
// - Eight tripped cycles total enter hiccup, conversion off 20 ms.
// - After hiccup, clear state and restart; repeat while overload lasts.
// - Fault threshold programmable 16-56 A, others accepted too.
// - Fault response: eight limited cycles then latch or hiccup.
// - Three consecutive trips halve duty limit down to 0.125.
// - No duty reduction if running below 0.125 at onset.
// - Four consecutive clear cycles double the limit back to nominal.
// - Temperature byte in degrees, true value is byte plus 40.
// - Above 125 degrees conversion stops, restarting when cooled.
// - Thermal trip and restart points differ by 25 degrees.
// - Thermal limit and response programmable: ignore, inhibit, latch.
module cfm_fault_manager #(
  parameter int MS_CYCLES = cfm_pkg::MS_CYCLES,
  parameter int OC_TOTAL_MAX = cfm_pkg::OC_TOTAL_MAX
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Settings and control pins
  input wire cfm_pkg::cfm_cfg_type cfg,
  input wire logic enPin,
  input wire logic ocCompIn,
  // Telemetry inputs
  input wire logic [11:0] iAvg,
  input wire logic [7:0] tempCode,
  // Drivers
  output logic hsDrive,
  output logic lsDrive,
  output logic convEn,
  output logic setPulse,
  // Comparator threshold and readback
  output logic [5:0] ocThresholdA,
  output logic [11:0] readIout,
  output logic [7:0] currentReadbackByte,
  output logic [7:0] dieHeatReadout,
  output logic [8:0] dieHeatReportCommand,
  output cfm_pkg::cfm_status_type status
);
  localparam logic [15:0] SAMPLE_LEN = 16'(cfm_pkg::SAMPLE_CYCLES);
  localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);
  localparam logic [3:0] TOTAL_MAX = 4'(OC_TOTAL_MAX);

  logic [1:0] rstPipe;
  logic rstSync_n;
  cfm_pkg::cfm_state_type state;
  cfm_pkg::cfm_state_type next_state;
  logic [10:0] freqClamped;
  logic [15:0] periodCalc;
  logic [15:0] period;
  logic [15:0] phase;
  logic [15:0] setLen;
  logic [15:0] onCycles;
  logic [23:0] onProduct;
  logic [7:0] dutyEff;
  logic [7:0] dutyCap;
  logic cycleEnd;
  logic switching;
  logic killNow;
  logic next_hs;
  logic next_ls;
  logic ocSeen;
  logic [3:0] ocTotal;
  logic [1:0] overRun;
  logic [2:0] underRun;
  logic [1:0] dutyStep;
  logic reduceOk;
  logic clearOc;
  logic [17:0] msCount;
  logic msTick;
  logic wantOn;
  logic softPath;
  logic [8:0] tempC;
  logic otHot;
  logic otTrip;
  logic ocDone;
  logic seqLoad;
  logic [6:0] seqMs;
  logic seqDone;
  logic hicLoad;
  logic hicDone;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe[1];

  // Settings outside the range are clamped to its edges
  always_comb begin
    if (cfg.freqKhz < cfm_pkg::FREQ_MIN_KHZ) begin
      freqClamped = cfm_pkg::FREQ_MIN_KHZ;
    end else if (cfg.freqKhz > cfm_pkg::FREQ_MAX_KHZ) begin
      freqClamped = cfm_pkg::FREQ_MAX_KHZ;
    end else begin
      freqClamped = cfg.freqKhz;
    end
  end

  cfm_period_div #(
    .DIVIDEND(cfm_pkg::CLK_KHZ)
  ) u_div (
    .clk(core_clk),
    .rstSync_n(rstSync_n),
    .ce(ce),
    .divisor(freqClamped),
    .period(periodCalc)
  );

  // Millisecond tick shared by all timers
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      msCount <= 18'h00000;
      msTick <= 1'b0;
    end else if (ce) begin
      msTick <= (msCount == MS_LAST);
      msCount <= (msCount == MS_LAST) ? 18'h00000 : msCount + 18'h00001;
    end
  end

  // Conversion request: pin, optionally gated by the operation command
  assign wantOn = enPin && (!cfg.opCtrl || cfg.opOn);
  assign softPath = cfg.busMode && cfg.softOff;

  // Temperature with offset and hysteresis
  assign tempC = {1'b0, tempCode} + cfm_pkg::TEMP_OFFSET;
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      otHot <= 1'b0;
    end else if (ce) begin
      if (tempC > {1'b0, cfg.otLimit}) begin
        otHot <= 1'b1;
      end else if (tempC < {1'b0, cfg.otLimit} - cfm_pkg::OT_HYST) begin
        otHot <= 1'b0;
      end
    end
  end
  assign otTrip = otHot && (cfg.otResp != cfm_pkg::OT_IGNORE);
  assign ocDone = (ocTotal >= TOTAL_MAX);

  // Sequencing: turn-off delay then soft stop share one timer
  always_comb begin
    next_state = state;
    seqLoad = 1'b0;
    seqMs = cfg.offDelayMs;
    hicLoad = 1'b0;
    case (state)
      cfm_pkg::ST_OFF: begin
        if (wantOn && !otTrip) begin
          next_state = cfm_pkg::ST_RUN;
        end
      end
      cfm_pkg::ST_RUN: begin
        if (otTrip) begin
          next_state = (cfg.otResp == cfm_pkg::OT_LATCH) ?
                       cfm_pkg::ST_LATCHED : cfm_pkg::ST_OFF;
        end else if (!wantOn) begin
          if (softPath) begin
            next_state = cfm_pkg::ST_DELAY;
            seqLoad = 1'b1;
          end else begin
            next_state = cfm_pkg::ST_OFF;
          end
        end else if (ocDone) begin
          if (cfg.ocLatch) begin
            next_state = cfm_pkg::ST_LATCHED;
          end else begin
            next_state = cfm_pkg::ST_HICCUP;
            hicLoad = 1'b1;
          end
        end
      end
      cfm_pkg::ST_DELAY: begin
        if (otTrip) begin
          next_state = cfm_pkg::ST_OFF;
        end else if (seqDone) begin
          next_state = cfm_pkg::ST_SOFT;
          seqLoad = 1'b1;
          seqMs = (cfg.stopMs == 7'h00) ? 7'h01 : cfg.stopMs;
        end
      end
      cfm_pkg::ST_SOFT: begin
        if (otTrip || seqDone) begin
          next_state = cfm_pkg::ST_OFF;
        end
      end
      cfm_pkg::ST_HICCUP: begin
        if (hicDone) begin
          next_state = wantOn ? cfm_pkg::ST_RUN : cfm_pkg::ST_OFF;
        end
      end
      cfm_pkg::ST_LATCHED: begin
        if (!wantOn) begin
          next_state = cfm_pkg::ST_OFF;
        end
      end
      default: begin
        next_state = cfm_pkg::ST_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state <= cfm_pkg::ST_OFF;
    end else if (ce) begin
      state <= next_state;
    end
  end

  cfm_ms_countdown #(
    .W(7)
  ) u_seq (
    .clk(core_clk),
    .rstSync_n(rstSync_n),
    .ce(ce),
    .tick(msTick),
    .load(seqLoad),
    .loadMs(seqMs),
    .busy(),
    .done(seqDone)
  );

  cfm_ms_countdown #(
    .W(5)
  ) u_hiccup (
    .clk(core_clk),
    .rstSync_n(rstSync_n),
    .ce(ce),
    .tick(msTick),
    .load(hicLoad),
    .loadMs(5'(cfm_pkg::HICCUP_MS)),
    .busy(),
    .done(hicDone)
  );

  // Switching runs through the delay and soft stop so output holds
  assign switching = (state == cfm_pkg::ST_RUN) ||
                     (state == cfm_pkg::ST_DELAY) ||
                     (state == cfm_pkg::ST_SOFT);
  // Drivers drop in the same cycle that the state machine leaves
  assign killNow = switching && !(next_state == cfm_pkg::ST_RUN ||
                   next_state == cfm_pkg::ST_DELAY ||
                   next_state == cfm_pkg::ST_SOFT);
  assign cycleEnd = switching && (phase >= period - 16'h0001);

  // Phase counter; new period taken only at a cycle boundary or while not switching
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      phase <= 16'h0000;
      period <= 16'h0190;
    end else if (ce) begin
      if (!switching || cycleEnd) begin
        phase <= 16'h0000;
        period <= periodCalc;
      end else begin
        phase <= phase + 16'h0001;
      end
    end
  end

  // Duty limit ladder; step 0 means nominal
  always_comb begin
    case (dutyStep)
      2'h1: dutyCap = cfm_pkg::DUTY_HALF;
      2'h2: dutyCap = cfm_pkg::DUTY_QUARTER;
      2'h3: dutyCap = cfm_pkg::DUTY_EIGHTH;
      default: dutyCap = 8'hff;
    endcase
    dutyEff = (cfg.dutyNom < dutyCap) ? cfg.dutyNom : dutyCap;
  end
  assign setLen = period >> cfm_pkg::SET_SHIFT;
  assign onProduct = period * {8'h00, dutyEff};
  assign onCycles = onProduct[23:8];

  // High side begins when the set pulse ends
  always_comb begin
    next_hs = switching && !killNow && (phase >= setLen) &&
              (phase < setLen + onCycles);
    next_ls = switching && !killNow && !next_hs;
  end

  // Registered drivers and enable
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      hsDrive <= 1'b0;
      lsDrive <= 1'b0;
      convEn <= 1'b0;
      setPulse <= 1'b0;
    end else if (ce) begin
      hsDrive <= next_hs;
      lsDrive <= next_ls;
      convEn <= switching && !killNow;
      setPulse <= switching && !killNow && (phase < setLen);
    end
  end

  // Valley sample window opens at the set pulse rise
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ocSeen <= 1'b0;
    end else if (ce) begin
      if (!switching || cycleEnd) begin
        ocSeen <= 1'b0;
      end else if (phase < SAMPLE_LEN && ocCompIn) begin
        ocSeen <= 1'b1;
      end
    end
  end

  // Counters cleared on hiccup entry and on any stop
  assign clearOc = !switching || killNow;

  // Per-cycle trip bookkeeping
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ocTotal <= 4'h0;
      overRun <= 2'h0;
      underRun <= 3'h0;
      dutyStep <= 2'h0;
      reduceOk <= 1'b0;
    end else if (ce) begin
      if (clearOc) begin
        ocTotal <= 4'h0;
        overRun <= 2'h0;
        underRun <= 3'h0;
        dutyStep <= 2'h0;
        reduceOk <= 1'b0;
      end else if (cycleEnd && ocSeen) begin
        underRun <= 3'h0;
        if (ocTotal < TOTAL_MAX) begin
          ocTotal <= ocTotal + 4'h1;
        end
        if (dutyStep == 2'h0 && overRun == 2'h0) begin
          reduceOk <= (cfg.dutyNom >= cfm_pkg::DUTY_EIGHTH);
        end
        if (overRun == cfm_pkg::OC_STEP_RUN - 2'h1) begin
          overRun <= 2'h0;
          if (reduceOk && dutyStep < cfm_pkg::STEP_MAX) begin
            dutyStep <= dutyStep + 2'h1;
          end
        end else begin
          overRun <= overRun + 2'h1;
        end
      end else if (cycleEnd) begin
        overRun <= 2'h0;
        if (underRun == cfm_pkg::OC_RECOVER_RUN - 3'h1) begin
          underRun <= 3'h0;
          if (dutyStep != 2'h0) begin
            dutyStep <= dutyStep - 2'h1;
          end
        end else begin
          underRun <= underRun + 3'h1;
        end
      end
    end
  end

  // Telemetry readback and status
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      readIout <= 12'h000;
      currentReadbackByte <= 8'h00;
      dieHeatReadout <= 8'h00;
      dieHeatReportCommand <= 9'h000;
      ocThresholdA <= 6'h00;
      status <= '0;
    end else if (ce) begin
      readIout <= iAvg;
      // Quarter-amp byte saturates rather than wrapping on big loads
      currentReadbackByte <= (iAvg[11:10] != 2'h0) ? 8'hff :
                             iAvg[9:2];
      dieHeatReadout <= tempCode;
      dieHeatReportCommand <= tempC;
      // Any limit is passed on; accuracy is best on 4 A steps 16-56 A
      ocThresholdA <= cfg.ocLimitA;
      status.ocWarn <= (iAvg > cfg.warnLimit);
      status.ocFault <= ocDone;
      status.otFault <= otHot;
      status.latched <= (next_state == cfm_pkg::ST_LATCHED);
      status.softStop <= (next_state == cfm_pkg::ST_SOFT);
      status.dutyStep <= dutyStep;
    end
  end

  // Immediate stop in default mode
  enable_off_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    ce && state == cfm_pkg::ST_RUN && !wantOn && !softPath && !otTrip
    |=> !hsDrive && !lsDrive && !convEn)
    else $error("drivers still on after enable drop");

  // No high side while the set pulse is up
  hs_after_set_a: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    hsDrive |-> !setPulse && !lsDrive)
    else $error("high side overlaps set pulse or low side");

  // Eight trips end the run
  oc_limit_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    ce && state == cfm_pkg::ST_RUN && ocDone && wantOn && !otTrip
    |=> state == cfm_pkg::ST_HICCUP || state == cfm_pkg::ST_LATCHED)
    else $error("over-current total did not stop conversion");

  // Hiccup holds conversion off with counters cleared
  hiccup_off_a: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    state == cfm_pkg::ST_HICCUP && $past(state) == cfm_pkg::ST_HICCUP
    |-> !convEn && ocTotal == 4'h0 && dutyStep == 2'h0)
    else $error("hiccup left conversion or counters active");

  // Duty step rises only on the third consecutive trip
  step_down_a: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    ce && dutyStep != 2'h3 && !clearOc ##1 dutyStep == $past(dutyStep) + 2'h1
    |-> $past(overRun) == 2'h2 && $past(ocSeen) && $past(cycleEnd))
    else $error("duty step without three trips");

  // Duty step falls only after four clear cycles
  step_up_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    ce && dutyStep != 2'h0 && !clearOc ##1 dutyStep == $past(dutyStep) - 2'h1
    |-> $past(underRun) == 3'h3 && !$past(ocSeen))
    else $error("duty restored without four clear cycles");

  // Thermal restart only below the hysteresis point
  ot_hyst_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    $fell(otHot) |-> $past(tempC) < {1'b0, $past(cfg.otLimit)} - 9'h019)
    else $error("thermal flag cleared inside hysteresis");

  // Latched state survives while conversion is still requested
  latch_hold_a: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    ce && state == cfm_pkg::ST_LATCHED && wantOn
    |=> state == cfm_pkg::ST_LATCHED && !convEn)
    else $error("latched shutdown released without off cycle");

  // Quarter-amp byte follows the average current
  current_byte_a: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    ce && iAvg < 12'h400 |=> currentReadbackByte == $past(iAvg[9:2]))
    else $error("current byte mismatch");

endmodule

// ==== verif/cfm_host_model.sv ====
// Management host model: owns the setting word seen by the fault manager.
// Assumes the bench changes settings only between clock edges.
`timescale 1ns/10ps
module cfm_host_model (
  // Settings to the block
  output cfm_pkg::cfm_cfg_type cfg
);
  // Start-up settings; offset frequency keeps telemetry clean
  initial begin
    cfg = '0;
    cfg.freqKhz = 11'h3d2; // 978 kHz, not the round value
    cfg.ocLimitA = 6'h10;
    cfg.warnLimit = 12'h100;
    cfg.otLimit = 8'h7d;
    cfg.otResp = cfm_pkg::OT_INHIBIT;
    cfg.dutyNom = 8'h80;
  end
  // Whole word replaced at once, as one block write would
  task automatic put(input cfm_pkg::cfm_cfg_type c);
    cfg = c;
  endtask
endmodule

// ==== verif/converter_fault_manager_tb.sv ====
// Self-checking bench of the fault manager with a host model.
// Assumes a 20-cycle millisecond so hiccup lasts 400 cycles.
`timescale 1ns/10ps
module converter_fault_manager_tb;
  logic core_clk;
  logic rst_n;
  logic enPin;
  logic ocCompIn;
  logic [11:0] iAvg;
  logic [7:0] tempCode;
  logic hsDrive;
  logic lsDrive;
  logic convEn;
  logic setPulse;
  logic [5:0] ocThresholdA;
  logic [11:0] readIout;
  logic [7:0] currentReadbackByte;
  logic [7:0] dieHeatReadout;
  logic [8:0] dieHeatReportCommand;
  cfm_pkg::cfm_status_type status;
  cfm_pkg::cfm_cfg_type cfg;
  cfm_pkg::cfm_cfg_type c;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  logic softSeen;

  cfm_host_model host (.cfg(cfg));
  cfm_fault_manager #(.MS_CYCLES(20), .OC_TOTAL_MAX(8)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .cfg(cfg),
    .enPin(enPin), .ocCompIn(ocCompIn), .iAvg(iAvg), .tempCode(tempCode),
    .hsDrive(hsDrive), .lsDrive(lsDrive), .convEn(convEn),
    .setPulse(setPulse), .ocThresholdA(ocThresholdA), .readIout(readIout),
    .currentReadbackByte(currentReadbackByte),
    .dieHeatReadout(dieHeatReadout),
    .dieHeatReportCommand(dieHeatReportCommand), .status(status));

  // 200 MHz clock
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Watchdog: the open-ended waits below lean on this ceiling
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(string nm, logic [11:0] e, logic [11:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic untilEn(logic v);
    while (convEn !== v) @(negedge core_clk);
  endtask

  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic t_read();
    iAvg = 12'h3a5;
    tempCode = 8'h3c;
    repeat (3) @(negedge core_clk);
    chk("iout", 12'h3a5, readIout);
    chk("ibyte", 12'h0e9, {4'h0, currentReadbackByte});
    chk("tbyte", 12'h03c, {4'h0, dieHeatReadout});
    chk("tdeg", 12'h064, {3'h0, dieHeatReportCommand});
    chk("warn", 12'h1, {11'h0, status.ocWarn});
    iAvg = 12'hfff;
    repeat (3) @(negedge core_clk);
    chk("isat", 12'h0ff, {4'h0, currentReadbackByte});
    iAvg = 12'h0f0;
    repeat (3) @(negedge core_clk);
    chk("nowarn", 12'h0, {11'h0, status.ocWarn});
    $display("test read done");
  endtask

  task automatic t_switch();
    enPin = 1;
    untilEn(1);
    chk("thr", 12'h010, {6'h0, ocThresholdA});
    @(posedge setPulse);
    n = 0;
    @(negedge core_clk);
    while (setPulse === 1'b1) begin
      chk("hsset", 12'h0, {11'h0, hsDrive});
      n++;
      @(negedge core_clk);
    end
    chk("setlen", 12'h019, n[11:0]);
    repeat (2) @(negedge core_clk);
    chk("hson", 12'h1, {11'h0, hsDrive});
    enPin = 0;
    repeat (2) @(negedge core_clk);
    chk("drvoff", 12'h0, {10'h0, hsDrive, lsDrive});
    $display("test switch done");
  endtask

  task automatic t_hiccup();
    enPin = 1;
    ocCompIn = 1;
    repeat (2) begin
      untilEn(1);
      untilEn(0);
      n = 0;
      while (convEn === 1'b0) begin
        n++;
        @(negedge core_clk);
      end
      chk("hicc", 12'h1, {11'h0, n >= 380 && n <= 402});
      chk("step", 12'h0, {10'h0, status.dutyStep});
    end
    ocCompIn = 0;
    $display("test hiccup done");
  endtask

  task automatic t_step();
    enPin = 1;
    untilEn(1);
    ocCompIn = 1;
    while (status.dutyStep !== 2'h2) @(negedge core_clk);
    ocCompIn = 0;
    @(posedge hsDrive);
    n = 0;
    @(negedge core_clk);
    while (hsDrive === 1'b1) begin
      n++;
      @(negedge core_clk);
    end
    chk("hsquart", 12'h033, n[11:0]);
    chk("ocflt", 12'h0, {11'h0, status.ocFault});
    repeat (2000) @(negedge core_clk);
    chk("stepup", 12'h0, {10'h0, status.dutyStep});
    enPin = 0;
    repeat (3) @(negedge core_clk);
    c = cfg;
    c.dutyNom = 8'h18;
    host.put(c);
    enPin = 1;
    untilEn(1);
    ocCompIn = 1;
    repeat (1000) @(negedge core_clk);
    chk("lowduty", 12'h0, {10'h0, status.dutyStep});
    ocCompIn = 0;
    enPin = 0;
    c.dutyNom = 8'h80;
    host.put(c);
    repeat (3) @(negedge core_clk);
    $display("test step done");
  endtask

  task automatic t_soft();
    c = cfg;
    c.busMode = 1;
    c.softOff = 1;
    c.opCtrl = 1;
    c.opOn = 1;
    c.offDelayMs = 7'h02;
    c.stopMs = 7'h03;
    host.put(c);
    enPin = 1;
    untilEn(1);
    repeat (5) @(negedge core_clk);
    c.opOn = 0;
    host.put(c);
    n = 0;
    softSeen = 0;
    while (convEn === 1'b1) begin
      n++;
      softSeen = softSeen | status.softStop;
      @(negedge core_clk);
    end
    chk("softoff", 12'h1, {11'h0, n >= 80 && n <= 102});
    chk("softflag", 12'h1, {11'h0, softSeen});
    c.busMode = 0;
    c.opOn = 1;
    host.put(c);
    untilEn(1);
    c.opOn = 0;
    host.put(c);
    repeat (2) @(negedge core_clk);
    chk("opoff", 12'h0, {11'h0, convEn});
    c.opCtrl = 0;
    c.softOff = 0;
    host.put(c);
    $display("test soft done");
  endtask

  task automatic t_latch();
    c = cfg;
    c.ocLatch = 1;
    host.put(c);
    ocCompIn = 1;
    while (status.latched !== 1'b1) @(negedge core_clk);
    ocCompIn = 0;
    repeat (500) @(negedge core_clk);
    chk("latch", 12'h0, {11'h0, convEn});
    enPin = 0;
    repeat (3) @(negedge core_clk);
    enPin = 1;
    untilEn(1);
    chk("unlat", 12'h0, {11'h0, status.latched});
    $display("test latch done");
  endtask

  task automatic t_heat();
    tempCode = 8'h56;
    untilEn(0);
    chk("otf", 12'h1, {11'h0, status.otFault});
    tempCode = 8'h3d;
    repeat (20) @(negedge core_clk);
    chk("hyst", 12'h0, {11'h0, convEn});
    tempCode = 8'h3b;
    untilEn(1);
    c = cfg;
    c.otResp = cfm_pkg::OT_LATCH;
    host.put(c);
    tempCode = 8'h56;
    untilEn(0);
    tempCode = 8'h3b;
    repeat (20) @(negedge core_clk);
    chk("otlat", 12'h0, {11'h0, convEn});
    c.otResp = cfm_pkg::OT_IGNORE;
    host.put(c);
    enPin = 0;
    repeat (3) @(negedge core_clk);
    enPin = 1;
    untilEn(1);
    tempCode = 8'h56;
    repeat (20) @(negedge core_clk);
    chk("otign", 12'h1, {11'h0, convEn});
    $display("test heat done");
  endtask

  // Main sequence
  initial begin
    rst_n = 0;
    enPin = 0;
    ocCompIn = 0;
    iAvg = 12'h0;
    tempCode = 8'h3c;
    repeat (10) @(negedge core_clk);
    rst_n = 1;
    repeat (3) @(negedge core_clk);
    t_read();
    t_switch();
    t_step();
    t_soft();
    t_hiccup();
    t_latch();
    t_heat();
    test_done();
  end
endmodule
